/* bertic_pkg.sv */
// constants, register map and types for the BER test interval controller
// Behaviour
// - beep each second BER above alert threshold
// - alert threshold ten to minus 2..16
// - show threshold seven seconds after key
// - four loudness levels, lowest is off
// - loudness key beeps unless level minimum
// - clock idle flag after 20 ms
// - data idle flag on data or clock
// - weak signal flag while level hunt enabled
// - two test states; run accumulates new results
// - stop freezes results of last intervals
// - indicator blinks stopped, steady when running
// - indicator letter names the timing mode
// - clear key while stopped starts interval
// - clear key while running stops interval
// - manual mode starts and stops on keys
// - timed mode stops after test length
// - repeat mode restarts every test length
// - repeat mode still honours manual stop
// - total and window processes always run
// - clear key zeroes displayed background process
// - history clear resets latched indicators
// - length held as hours, minutes, seconds
// - seconds come from internal time base
// - history indicators latch until cleared
package bertic_pkg;
  // ==========================================
  // clock and timing
  localparam int unsigned CLK_HZ = 40_000_000;
  localparam int unsigned SEC_S = 1;
  localparam int unsigned IDLE_MS = 20;
  localparam int unsigned SEC_CYC_DEF = CLK_HZ * SEC_S;
  localparam int unsigned IDLE_CYC_DEF = CLK_HZ / 1000 * IDLE_MS;
  localparam logic [2:0] SHOW_SEC = 3'h7;
  // ==========================================
  // register byte offsets
  localparam logic [4:0] REG_CTRL = 5'h00;
  localparam logic [4:0] REG_LENGTH = 5'h04;
  localparam logic [4:0] REG_KEYS = 5'h08;
  localparam logic [4:0] REG_STATUS = 5'h0C;
  // ==========================================
  // field positions
  localparam int MODE_LSB = 0;
  localparam int DISP_LSB = 2;
  localparam int HUNT_BIT = 4;
  localparam int LEN_S_LSB = 0;
  localparam int LEN_M_LSB = 8;
  localparam int LEN_H_LSB = 16;
  localparam int K_CLEAR = 0;
  localparam int K_HCLEAR = 1;
  localparam int K_THR_UP = 2;
  localparam int K_THR_DN = 3;
  localparam int K_VOL_UP = 4;
  localparam int K_VOL_DN = 5;
  // ==========================================
  // encodings and reset values
  localparam logic [1:0] MODE_MANUAL = 2'h0;
  localparam logic [1:0] MODE_TIMED = 2'h1;
  localparam logic [1:0] MODE_REPEAT = 2'h2;
  localparam logic [1:0] DISP_TEST = 2'h0;
  localparam logic [1:0] DISP_TOTAL = 2'h1;
  localparam logic [1:0] DISP_WINDOW = 2'h2;
  localparam logic [7:0] CHAR_U = 8'h55;
  localparam logic [7:0] CHAR_T = 8'h54;
  localparam logic [7:0] CHAR_R = 8'h52;
  localparam logic [4:0] THR_MIN = 5'h02;
  localparam logic [4:0] THR_MAX = 5'h10;
  localparam logic [4:0] THR_RST = 5'h06;
  localparam logic [1:0] VOL_MAX = 2'h3;
  localparam logic [31:0] LEN_RST = 32'h0001_0000;
  typedef enum logic {BERTIC_STOPPED, BERTIC_STARTED} bertic_ti_e;
endpackage

/* bertic_top.sv */
// BER test interval controller: time base, test process, alert, idle flags
`timescale 1ns/1ps
module bertic_top #(
  parameter int unsigned SEC_CYC = bertic_pkg::SEC_CYC_DEF,
  parameter int unsigned IDLE_CYC = bertic_pkg::IDLE_CYC_DEF
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic [4:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  input wire logic ana_clk,
  input wire logic ana_data,
  input wire logic weak_in,
  input wire logic [4:0] ber_exp,
  input wire logic bit_err_ev,
  input wire logic phase_err_ev,
  input wire logic power_loss_ev,
  output logic test_running,
  output logic [7:0] test_char,
  output logic test_char_on,
  output logic test_start,
  output logic total_clear,
  output logic window_clear,
  output logic clock_idle,
  output logic data_idle,
  output logic weak_signal_flag,
  output logic [4:0] alert_thr_exp,
  output logic thr_show,
  output logic [1:0] alert_loudness,
  output logic beep,
  output logic [2:0] hist
);
  localparam logic [31:0] HALF_CYC = 32'(SEC_CYC / 2);
  localparam logic [31:0] IDLE_LIM = 32'(IDLE_CYC);

  // saturating idle timer, restarted by any transition
  function automatic logic [31:0] idle_next(input logic edge_seen,
                                            input logic [31:0] cnt);
    if (edge_seen)
      idle_next = 32'h0;
    else if (cnt >= IDLE_LIM)
      idle_next = cnt;
    else
      idle_next = cnt + 32'h1;
  endfunction

  // indicator letter for a timing mode; unused code acts as manual
  function automatic logic [7:0] mode_char(input logic [1:0] m);
    case (m)
      bertic_pkg::MODE_TIMED: mode_char = bertic_pkg::CHAR_T;
      bertic_pkg::MODE_REPEAT: mode_char = bertic_pkg::CHAR_R;
      default: mode_char = bertic_pkg::CHAR_U;
    endcase
  endfunction

  // ==========================================
  // avalon slave: one wait state, then answer
  logic [31:0] ctrl, next_ctrl, length, next_length, next_readdata;
  logic next_waitrequest, taken, key_wr;
  logic k_clr, k_hclr, k_tup, k_tdn, k_vup, k_vdn;
  logic [31:0] status;
  logic [1:0] mode, disp;
  logic [31:0] len_sec;

  assign taken = (read || write) && !waitrequest;
  assign key_wr = write && !waitrequest && address == bertic_pkg::REG_KEYS;
  assign k_clr = key_wr && writedata[bertic_pkg::K_CLEAR];
  assign k_hclr = key_wr && writedata[bertic_pkg::K_HCLEAR];
  assign k_tup = key_wr && writedata[bertic_pkg::K_THR_UP];
  assign k_tdn = key_wr && writedata[bertic_pkg::K_THR_DN];
  assign k_vup = key_wr && writedata[bertic_pkg::K_VOL_UP];
  assign k_vdn = key_wr && writedata[bertic_pkg::K_VOL_DN];
  assign mode = ctrl[bertic_pkg::MODE_LSB +: 2];
  assign disp = ctrl[bertic_pkg::DISP_LSB +: 2];
  // length kept as three separate fields, summed only for compare
  assign len_sec = 32'(length[bertic_pkg::LEN_H_LSB +: 8]) * 32'h0E10
    + 32'(length[bertic_pkg::LEN_M_LSB +: 6]) * 32'h3C
    + 32'(length[bertic_pkg::LEN_S_LSB +: 6]);
  assign status = {test_char, 7'h00, thr_show, alert_loudness, 1'b0,
    alert_thr_exp, 1'b0, hist, weak_signal_flag, data_idle, clock_idle,
    test_running};

  always_comb begin
    next_ctrl = ctrl;
    next_length = length;
    next_readdata = readdata;
    next_waitrequest = !((read || write) && waitrequest);
    if (write && !waitrequest && address == bertic_pkg::REG_CTRL)
      next_ctrl = {27'h0, writedata[4:0]};
    if (write && !waitrequest && address == bertic_pkg::REG_LENGTH)
      next_length = writedata & 32'h00FF_3F3F;
    // answer is loaded while waitrequest is still high
    if (read && waitrequest) begin
      case (address)
        bertic_pkg::REG_CTRL: next_readdata = ctrl;
        bertic_pkg::REG_LENGTH: next_readdata = length;
        bertic_pkg::REG_STATUS: next_readdata = status;
        default: next_readdata = 32'h0;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      ctrl <= 32'h0;
      length <= bertic_pkg::LEN_RST;
      readdata <= 32'h0;
      waitrequest <= 1'b1;
    end else begin
      ctrl <= next_ctrl;
      length <= next_length;
      readdata <= next_readdata;
      waitrequest <= next_waitrequest;
    end
  end

  // ==========================================
  // internal time base: half-second blink, second tick
  logic [31:0] half_cnt, next_half_cnt;
  logic blink, next_blink, sec_tick, next_sec_tick;

  always_comb begin
    next_half_cnt = half_cnt + 32'h1;
    next_blink = blink;
    next_sec_tick = 1'b0;
    if (half_cnt >= HALF_CYC - 32'h1) begin
      next_half_cnt = 32'h0;
      next_blink = !blink;
      next_sec_tick = blink;
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      half_cnt <= 32'h0;
      blink <= 1'b0;
      sec_tick <= 1'b0;
    end else begin
      half_cnt <= next_half_cnt;
      blink <= next_blink;
      sec_tick <= next_sec_tick;
    end
  end

  // ==========================================
  // input activity: pins pass two flops before use
  logic [2:0] ck_sy, dt_sy;
  logic [1:0] wk_sy;
  logic [31:0] ck_cnt, next_ck_cnt, dt_cnt, next_dt_cnt;
  logic next_clock_idle, next_data_idle, next_weak;

  always_comb begin
    next_ck_cnt = idle_next(ck_sy[2] ^ ck_sy[1], ck_cnt);
    next_dt_cnt = idle_next(dt_sy[2] ^ dt_sy[1], dt_cnt);
    next_clock_idle = next_ck_cnt >= IDLE_LIM;
    next_data_idle = next_dt_cnt >= IDLE_LIM || next_clock_idle;
    next_weak = ctrl[bertic_pkg::HUNT_BIT] && wk_sy[1];
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      ck_sy <= 3'h0;
      dt_sy <= 3'h0;
      wk_sy <= 2'h0;
      ck_cnt <= 32'h0;
      dt_cnt <= 32'h0;
      clock_idle <= 1'b0;
      data_idle <= 1'b0;
      weak_signal_flag <= 1'b0;
    end else begin
      ck_sy <= {ck_sy[1:0], ana_clk};
      dt_sy <= {dt_sy[1:0], ana_data};
      wk_sy <= {wk_sy[0], weak_in};
      ck_cnt <= next_ck_cnt;
      dt_cnt <= next_dt_cnt;
      clock_idle <= next_clock_idle;
      data_idle <= next_data_idle;
      weak_signal_flag <= next_weak;
    end
  end

  // ==========================================
  // test process and background clears
  bertic_pkg::bertic_ti_e ti, next_ti;
  logic [31:0] el_sec, next_el_sec;
  logic next_start, next_tot_clr, next_win_clr;

  always_comb begin
    next_ti = ti;
    next_el_sec = el_sec;
    next_start = 1'b0;
    next_tot_clr = 1'b0;
    next_win_clr = 1'b0;
    if (k_clr && disp == bertic_pkg::DISP_TEST) begin
      case (ti)
        bertic_pkg::BERTIC_STARTED: next_ti = bertic_pkg::BERTIC_STOPPED;
        default: begin
          next_ti = bertic_pkg::BERTIC_STARTED;
          next_el_sec = 32'h0;
          next_start = 1'b1;
        end
      endcase
    end else if (k_clr && disp == bertic_pkg::DISP_TOTAL) begin
      next_tot_clr = 1'b1;
    end else if (k_clr && disp == bertic_pkg::DISP_WINDOW) begin
      next_win_clr = 1'b1;
    end else if (ti == bertic_pkg::BERTIC_STARTED && sec_tick
                 && (mode == bertic_pkg::MODE_TIMED
                     || mode == bertic_pkg::MODE_REPEAT)) begin
      // manual mode never reaches here, so only keys move it
      if (el_sec + 32'h1 >= len_sec) begin
        next_el_sec = 32'h0;
        if (mode == bertic_pkg::MODE_REPEAT)
          next_start = 1'b1;
        else
          next_ti = bertic_pkg::BERTIC_STOPPED;
      end else begin
        next_el_sec = el_sec + 32'h1;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      ti <= bertic_pkg::BERTIC_STOPPED;
      el_sec <= 32'h0;
      test_start <= 1'b0;
      total_clear <= 1'b0;
      window_clear <= 1'b0;
      test_running <= 1'b0;
      test_char <= bertic_pkg::CHAR_U;
      test_char_on <= 1'b0;
    end else begin
      ti <= next_ti;
      el_sec <= next_el_sec;
      test_start <= next_start;
      total_clear <= next_tot_clr;
      window_clear <= next_win_clr;
      test_running <= next_ti == bertic_pkg::BERTIC_STARTED;
      test_char <= mode_char(next_ctrl[bertic_pkg::MODE_LSB +: 2]);
      test_char_on <= next_ti == bertic_pkg::BERTIC_STARTED || next_blink;
    end
  end

  // ==========================================
  // alert threshold, loudness, beeps, history
  logic [4:0] next_thr;
  logic [1:0] next_vol;
  logic [2:0] show_cnt, next_show_cnt;
  logic next_beep, above;
  logic [2:0] next_hist;

  // second's BER lies at or above ten to minus threshold
  assign above = ber_exp != 5'h00 && ber_exp <= alert_thr_exp;

  always_comb begin
    next_thr = alert_thr_exp;
    next_vol = alert_loudness;
    next_show_cnt = show_cnt;
    next_beep = 1'b0;
    if (k_tup && !k_tdn && alert_thr_exp < bertic_pkg::THR_MAX)
      next_thr = alert_thr_exp + 5'h01;
    else if (k_tdn && !k_tup && alert_thr_exp > bertic_pkg::THR_MIN)
      next_thr = alert_thr_exp - 5'h01;
    // countdown in whole seconds, so shown time is six to seven s
    if (k_tup || k_tdn)
      next_show_cnt = bertic_pkg::SHOW_SEC;
    else if (sec_tick && show_cnt != 3'h0)
      next_show_cnt = show_cnt - 3'h1;
    if (k_vup && !k_vdn && alert_loudness < bertic_pkg::VOL_MAX)
      next_vol = alert_loudness + 2'h1;
    else if (k_vdn && !k_vup && alert_loudness != 2'h0)
      next_vol = alert_loudness - 2'h1;
    if ((k_vup || k_vdn) && next_vol != 2'h0)
      next_beep = 1'b1;
    if (sec_tick && above && alert_loudness != 2'h0)
      next_beep = 1'b1;
    // an event in the clearing cycle still latches
    next_hist = k_hclr ? 3'h0 : hist;
    next_hist = next_hist | {power_loss_ev, phase_err_ev, bit_err_ev};
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      alert_thr_exp <= bertic_pkg::THR_RST;
      alert_loudness <= 2'h0;
      show_cnt <= 3'h0;
      thr_show <= 1'b0;
      beep <= 1'b0;
      hist <= 3'h0;
    end else begin
      alert_thr_exp <= next_thr;
      alert_loudness <= next_vol;
      show_cnt <= next_show_cnt;
      thr_show <= next_show_cnt != 3'h0;
      beep <= next_beep;
      hist <= next_hist;
    end
  end

  // ==========================================
  // checks
  property p_thr_range;
    @(posedge clock) disable iff (!reset_n)
      alert_thr_exp >= 5'h02 && alert_thr_exp <= 5'h10;
  endproperty
  a_thr_range: assert property (p_thr_range)
    else $error("alert threshold out of range");

  property p_thr_up;
    @(posedge clock) disable iff (!reset_n)
      (k_tup && !k_tdn && alert_thr_exp < 5'h10)
      |=> alert_thr_exp == $past(alert_thr_exp) + 5'h01 && thr_show;
  endproperty
  a_thr_up: assert property (p_thr_up)
    else $error("threshold up key not applied");

  property p_vol_beep;
    @(posedge clock) disable iff (!reset_n)
      (k_vup && !k_vdn && alert_loudness < 2'h3) |=> beep;
  endproperty
  a_vol_beep: assert property (p_vol_beep)
    else $error("no beep on loudness key");

  property p_alert;
    @(posedge clock) disable iff (!reset_n)
      (sec_tick && above && alert_loudness != 2'h0) |=> beep;
  endproperty
  a_alert: assert property (p_alert)
    else $error("missing alert beep");

  property p_clr_stop;
    @(posedge clock) disable iff (!reset_n)
      (k_clr && disp == 2'h0 && test_running) |=> !test_running ##1 !test_running;
  endproperty
  a_clr_stop: assert property (p_clr_stop)
    else $error("clear key did not stop test");

  property p_clr_start;
    @(posedge clock) disable iff (!reset_n)
      (k_clr && disp == 2'h0 && !test_running) |=> test_running && test_start;
  endproperty
  a_clr_start: assert property (p_clr_start)
    else $error("clear key did not start test");

  property p_manual;
    @(posedge clock) disable iff (!reset_n)
      (mode == 2'h0 && test_running && !k_clr) |=> test_running;
  endproperty
  a_manual: assert property (p_manual)
    else $error("manual test stopped by itself");

  property p_hist;
    @(posedge clock) disable iff (!reset_n)
      (hist[0] && !k_hclr) |=> hist[0];
  endproperty
  a_hist: assert property (p_hist)
    else $error("history bit dropped");

  property p_steady;
    @(posedge clock) disable iff (!reset_n)
      test_running |-> test_char_on;
  endproperty
  a_steady: assert property (p_steady)
    else $error("indicator dark while running");

  property p_idle;
    @(posedge clock) disable iff (!reset_n)
      clock_idle |-> data_idle;
  endproperty
  a_idle: assert property (p_idle)
    else $error("clock idle without data idle");

  property p_bg;
    @(posedge clock) disable iff (!reset_n)
      (k_clr && disp == 2'h1) |=> total_clear && test_running == $past(test_running);
  endproperty
  a_bg: assert property (p_bg)
    else $error("total clear wrong");
endmodule // bertic_top

/* bertic_src.sv */
// source model: analyzer clock, data and comparator pins
`timescale 1ns/1ps
module bertic_src (
  input wire logic clk_on,
  input wire logic data_on,
  input wire logic weak_on,
  output logic ana_clk,
  output logic ana_data,
  output logic weak_in
);
  // ==========================================
  // link clock, 200 ns period, odd phase against the block clock
  initial begin
    ana_clk = 1'b0;
    ana_data = 1'b0;
    #37;
    forever begin
      #100;
      // clock stands still while switched off, so idle can be provoked
      if (clk_on) begin
        ana_clk = !ana_clk;
        // data moves on falling link edges only, stuck when data_on is low
        if (!ana_clk && data_on) begin
          ana_data = !ana_data;
        end
      end
    end
  end
  // comparator output follows the bench's request
  assign weak_in = weak_on;
endmodule // bertic_src

/* test_ber_test_interval_control.sv */
// self-checking bench for the BER test interval controller
`timescale 1ns/1ps
module test_ber_test_interval_control;
  // short second and idle spans keep the run brief
  localparam int SEC = 200;
  localparam int IDLE = 100;
  logic clock, reset_n, read, write, waitrequest, ana_clk, ana_data, weak_in;
  logic [4:0] address, ber_exp, alert_thr_exp;
  logic [31:0] writedata, readdata, q;
  logic [2:0] ev, hist;
  logic test_running, test_char_on, test_start, total_clear, window_clear;
  logic clock_idle, data_idle, weak_signal_flag, thr_show, beep;
  logic [7:0] test_char;
  logic [1:0] alert_loudness;
  logic clk_on, data_on, weak_on, a;
  int err_total, tests_run, n_start, n_beep, n_tot, n_win;
  int e_start, e_beep, m_thr, m_vol, n;
  bit up;
  // ==========================================
  // design and source
  bertic_top #(.SEC_CYC(SEC), .IDLE_CYC(IDLE)) bertic_top_i (.clock(clock), .reset_n(reset_n),
    .address(address), .read(read), .write(write), .writedata(writedata),
    .readdata(readdata), .waitrequest(waitrequest), .ana_clk(ana_clk), .ana_data(ana_data),
    .weak_in(weak_in), .ber_exp(ber_exp), .bit_err_ev(ev[0]), .phase_err_ev(ev[1]),
    .power_loss_ev(ev[2]), .test_running(test_running), .test_char(test_char),
    .test_char_on(test_char_on), .test_start(test_start), .total_clear(total_clear),
    .window_clear(window_clear), .clock_idle(clock_idle), .data_idle(data_idle),
    .weak_signal_flag(weak_signal_flag), .alert_thr_exp(alert_thr_exp),
    .thr_show(thr_show), .alert_loudness(alert_loudness), .beep(beep), .hist(hist));
  bertic_src bertic_src_i (.clk_on(clk_on), .data_on(data_on), .weak_on(weak_on),
    .ana_clk(ana_clk), .ana_data(ana_data), .weak_in(weak_in));
  // ==========================================
  // 40 MHz clock
  initial begin
    clock = 1'b0;
    forever #12.5 clock = !clock;
  end
  // pulse counters, so one-cycle outputs are never missed
  always @(posedge clock) begin
    if (test_start === 1'b1) n_start++;
    if (beep === 1'b1) n_beep++;
    if (total_clear === 1'b1) n_tot++;
    if (window_clear === 1'b1) n_win++;
  end
  // ==========================================
  // tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int c);
    repeat (c) @(posedge clock);
  endtask
  // one bus cycle: hold until waitrequest is sampled low, then release
  task automatic bus(input logic wr, input logic [4:0] ad, input logic [31:0] d);
    int w;
    w = 0;
    read <= !wr;
    write <= wr;
    address <= ad;
    writedata <= d;
    @(posedge clock);
    while (waitrequest !== 1'b0 && w < 50) begin
      @(posedge clock);
      w++;
    end
    if (w >= 50) chk(32'h0, 32'h1);
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
    @(posedge clock);
  endtask
  task automatic key(input int b);
    bus(1'b1, bertic_pkg::REG_KEYS, 32'h1 << b);
    cyc(2);
  endtask
  task automatic print_verdict;
    if (err_total == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // watchdog reckoned from about 4500 cycles of tests
  initial begin
    #400_000;
    err_total++;
    print_verdict();
  end
  // ==========================================
  // main sequence
  initial begin
    {read, write, address, writedata, ber_exp, ev, weak_on} = '0;
    clk_on = 1'b1;
    data_on = 1'b1;
    reset_n = 1'b0;
    m_thr = 6;
    m_vol = 0;
    void'($urandom(17));
    cyc(16);
    reset_n <= 1'b1;
    cyc(2);
    // reset values and register access, unmapped reads zero
    bus(1'b0, bertic_pkg::REG_STATUS, 0);
    chk(q, {bertic_pkg::CHAR_U, 8'h00, 3'h0, bertic_pkg::THR_RST, 8'h00});
    bus(1'b0, bertic_pkg::REG_LENGTH, 0);
    chk(q, bertic_pkg::LEN_RST);
    bus(1'b0, 5'h10, 0);
    chk(q, 32'h0);
    n = $urandom;
    bus(1'b1, bertic_pkg::REG_LENGTH, n);
    bus(1'b0, bertic_pkg::REG_LENGTH, 0);
    chk(q, n & 32'h00FF_3F3F);
    bus(1'b0, bertic_pkg::REG_KEYS, 0);
    chk(q, 32'h0);
    // threshold: up past the top, down past the bottom, back up to 6
    for (int i = 0; i < 36; i++) begin
      up = (i < 16) || (i >= 32);
      key(up ? bertic_pkg::K_THR_UP : bertic_pkg::K_THR_DN);
      m_thr = up ? (m_thr < 16 ? m_thr + 1 : 16) : (m_thr > 2 ? m_thr - 1 : 2);
      chk(alert_thr_exp, m_thr);
      chk(thr_show, 1'b1);
    end
    cyc(5 * SEC);
    chk(thr_show, 1'b1);
    cyc(3 * SEC);
    chk(thr_show, 1'b0);
    // loudness: saturate both ends, beep unless the new level is off
    for (int i = 0; i < 10; i++) begin
      up = (i < 4) || (i >= 8);
      key(up ? bertic_pkg::K_VOL_UP : bertic_pkg::K_VOL_DN);
      m_vol = up ? (m_vol < 3 ? m_vol + 1 : 3) : (m_vol > 0 ? m_vol - 1 : 0);
      if (m_vol != 0) e_beep++;
      chk(alert_loudness, m_vol);
      chk(n_beep, e_beep);
    end
    // alert: one beep per second above threshold, none below it
    ber_exp <= 5'($urandom_range(m_thr, 1));
    cyc(SEC);
    ber_exp <= 5'($urandom_range(16, m_thr + 1));
    e_beep++;
    cyc(SEC);
    ber_exp <= 5'h00;
    cyc(2);
    chk(n_beep, e_beep);
    // indicator letter per timing mode
    for (int m = 0; m < 3; m++) begin
      bus(1'b1, bertic_pkg::REG_CTRL, m);
      bus(1'b0, bertic_pkg::REG_STATUS, 0);
      chk(q[31:24], m == 0 ? bertic_pkg::CHAR_U : m == 1 ? bertic_pkg::CHAR_T
        : bertic_pkg::CHAR_R);
    end
    // manual: keys only start and stop, steady while running, blink stopped
    bus(1'b1, bertic_pkg::REG_CTRL, bertic_pkg::MODE_MANUAL);
    key(bertic_pkg::K_CLEAR);
    e_start++;
    chk(test_running, 1'b1);
    cyc(2 * SEC);
    chk(test_running, 1'b1);
    chk(test_char_on, 1'b1);
    key(bertic_pkg::K_CLEAR);
    chk(test_running, 1'b0);
    a = test_char_on;
    cyc(SEC / 2);
    chk(test_char_on, !a);
    // timed: stops by itself at the second tick reaching the length
    bus(1'b1, bertic_pkg::REG_LENGTH, 32'h2);
    bus(1'b1, bertic_pkg::REG_CTRL, bertic_pkg::MODE_TIMED);
    key(bertic_pkg::K_CLEAR);
    e_start++;
    n = 0;
    while (test_running === 1'b1 && n < 3 * SEC) begin
      @(posedge clock);
      n++;
    end
    chk(n >= SEC - 3 && n <= 2 * SEC, 1'b1);
    // repeat: restarts every second, still stopped by the key
    bus(1'b1, bertic_pkg::REG_LENGTH, 32'h1);
    bus(1'b1, bertic_pkg::REG_CTRL, bertic_pkg::MODE_REPEAT);
    // align to a second tick: the stopped blink falls with it
    @(negedge test_char_on);
    key(bertic_pkg::K_CLEAR);
    e_start += 4;
    cyc(3 * SEC);
    chk(n_start, e_start);
    chk(test_running, 1'b1);
    key(bertic_pkg::K_CLEAR);
    chk(test_running, 1'b0);
    cyc(2 * SEC);
    chk(n_start, e_start);
    // background processes: clear zeroes them, test stays stopped
    bus(1'b1, bertic_pkg::REG_CTRL, 32'h4);
    key(bertic_pkg::K_CLEAR);
    bus(1'b1, bertic_pkg::REG_CTRL, 32'h8);
    key(bertic_pkg::K_CLEAR);
    chk({n_tot[15:0], n_win[15:0]}, 32'h0001_0001);
    chk(test_running, 1'b0);
    // history indicators latch and clear
    for (int i = 0; i < 3; i++) begin
      ev <= 3'h1 << i;
      cyc(1);
      ev <= 3'h0;
      cyc(3);
      chk(hist, (3'h2 << i) - 3'h1);
    end
    key(bertic_pkg::K_HCLEAR);
    chk(hist, 3'h0);
    // idle detectors: clock stop, then data alone stuck
    chk({clock_idle, data_idle}, 2'h0);
    clk_on <= 1'b0;
    cyc(IDLE - 8);
    chk(clock_idle, 1'b0);
    cyc(20);
    chk({clock_idle, data_idle}, 2'h3);
    data_on <= 1'b0;
    clk_on <= 1'b1;
    cyc(30);
    chk({clock_idle, data_idle}, 2'h1);
    data_on <= 1'b1;
    cyc(30);
    chk(data_idle, 1'b0);
    // weak signal only with level hunt enabled
    weak_on <= 1'b1;
    cyc(6);
    chk(weak_signal_flag, 1'b0);
    bus(1'b1, bertic_pkg::REG_CTRL, 32'h1 << bertic_pkg::HUNT_BIT);
    cyc(4);
    chk(weak_signal_flag, 1'b1);
    print_verdict();
  end
endmodule // test_ber_test_interval_control
